// ===== eau_admission.sv
// Admission check and individual-data update for entitlement messages, on a Wishbone slave.
////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Decrypt only when received update number exceeds the stored one; else discard.
// - A received update number of zero skips the comparison entirely.
// - Top two protocol number bits pick the CBC initial value.
// - Lower six protocol number bits are ignored.
// - Decrypt with the device key paired to the matched device ID.
// - Model-type ID identifier selects the model tamper-check key.
// - Maker-type ID identifier selects the maker tamper-check key.
// - Tamper-check key depends on ID type only, never on generation.
// - Mismatching check value marks the message falsified and discards it.
// - Store the received update number for the sending station.
// - A received update number of zero leaves the stored one unchanged.
// - A received update number of all ones clears the stored one.
// - Tell work-key setup messages from device-key update messages.
// - Work-key setup copies flag, identifiers, pointers and keys unchanged.
// - Device-key update stores generation and parameter per station and ID type.
// - Compare the 48-bit device ID with held IDs; discard on no match.
//
// The implementer's own choices: the Wishbone register port and the address map.
module eau_admission (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Key selection toward the cipher engine, and the admission result
    output logic [1:0] dev_key_sel_o,
    output logic [1:0] cbc_sel_o,
    output logic tamper_key_sel_o,
    output eau_pkg::eau_result_type result_o
);
    import eau_pkg::*;
    `include "eau_map.svh"

    ////////////////////////////////////////////////////////////////////////////
    // Registers written by software, plus bus ack, sequencer and key-selection state.
    logic ack_q;
    logic [31:0] ctrl_q, hdr_q, id_lo_q, id_hi_q, chk_calc_q, chk_rx_q;
    logic [31:0] pay_q [`EAU_NUM_PAY];
    logic [31:0] model_lo_q, model_hi_q, maker_lo_q, maker_hi_q;
    eau_state_type state_q;
    eau_result_type result_q;
    logic [1:0] dev_key_q, cbc_q;
    logic tamper_q;

    // Byte-lane merge for a write.
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
        for (int b = 0; b < 4; b++) begin
            merge[b*8 +: 8] = sel[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
        end
    endfunction : merge

    // Bus decode: the write is taken on the edge where ack is given.
    wire bus_req = wb_cyc_i && wb_stb_i && !ack_q;
    wire wr = bus_req && wb_we_i;
    wire busy = (state_q != EAU_ST_IDLE);
    wire start = wr && (wb_adr_i == `EAU_ADR_CTRL) && wb_sel_i[0] && wb_dat_i[`EAU_CTRL_START] && !busy;
    wire [1:0] stn = ctrl_q[`EAU_CTRL_STN_LSB +: 2];

    // Message fields.
    wire [15:0] rx_upd = hdr_q[`EAU_HDR_UPD_MSB:0];
    wire [1:0] rx_cbc = hdr_q[`EAU_HDR_CBC_MSB:`EAU_HDR_CBC_LSB];
    wire rx_idtype = hdr_q[`EAU_HDR_IDTYPE];
    wire rx_kind = hdr_q[`EAU_HDR_KIND];
    wire eau_dev_id_type rx_id = {id_hi_q[15:0], id_lo_q};

    ////////////////////////////////////////////////////////////////////////////
    // Station storage and ID filter.
    wire [15:0] st_upd;
    wire [7:0] gen_model, gen_maker;
    wire [31:0] par_model, par_maker;
    wire [127:0] st_wk;
    wire id_match;
    wire [1:0] id_idx;
    wire in_store = (state_q == EAU_ST_STORE);
    wire upd_we = in_store && (rx_upd != `EAU_UPD_NONE);
    wire [15:0] upd_wdata = (rx_upd == `EAU_UPD_WRAP) ? `EAU_UPD_NONE : rx_upd;
    wire dk_we = in_store && rx_kind;
    wire wk_we = in_store && !rx_kind;

    eau_station_mem u_mem (
        .core_clk_i(core_clk_i),
        .sys_rst_i(sys_rst_i),
        .stn_i(stn),
        .upd_we_i(upd_we),
        .upd_wdata_i(upd_wdata),
        .dk_we_i(dk_we),
        .dk_type_i(rx_idtype),
        .dk_gen_i(pay_q[0][7:0]),
        .dk_param_i(pay_q[1]),
        .wk_we_i(wk_we),
        .wk_i({pay_q[3], pay_q[2], pay_q[1], pay_q[0]}),
        .upd_o(st_upd),
        .gen_model_o(gen_model),
        .gen_maker_o(gen_maker),
        .param_model_o(par_model),
        .param_maker_o(par_maker),
        .wk_o(st_wk)
    );

    eau_id_filter u_filter (
        .rx_id_i(rx_id),
        .model_id_i({model_hi_q[15:0], model_lo_q}),
        .maker_id_i({maker_hi_q[15:0], maker_lo_q}),
        .model_gen_i(gen_model),
        .maker_gen_i(gen_maker),
        .match_o(id_match),
        .match_idx_o(id_idx)
    );

    // Admission verdicts; a zero update number bypasses the comparison.
    wire upd_fresh = (rx_upd == `EAU_UPD_NONE) || (rx_upd > st_upd);
    wire chk_ok = (chk_calc_q == chk_rx_q);

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer: filter, then update check with key selection, then tamper check, then store.
    eau_state_type state_d;
    eau_result_type result_d;
    always_comb begin
        state_d = state_q;
        result_d = result_q;
        case (state_q)
            EAU_ST_IDLE: begin
                if (start) begin
                    state_d = EAU_ST_FILTER;
                    result_d = EAU_RES_NONE;
                end
            end
            EAU_ST_FILTER: begin
                if (!id_match) begin
                    state_d = EAU_ST_IDLE;
                    result_d = EAU_RES_ID_MISS;
                end else if (!upd_fresh) begin
                    state_d = EAU_ST_IDLE;
                    result_d = EAU_RES_STALE;
                end else begin
                    state_d = EAU_ST_CHECK;
                end
            end
            EAU_ST_CHECK: begin
                if (!chk_ok) begin
                    state_d = EAU_ST_IDLE;
                    result_d = EAU_RES_FALSIFIED;
                end else begin
                    state_d = EAU_ST_STORE;
                end
            end
            EAU_ST_STORE: begin
                state_d = EAU_ST_IDLE;
                result_d = EAU_RES_STORED;
            end
            default: begin
                state_d = EAU_ST_IDLE;
            end
        endcase
    end

    // Key selections are latched when the message passes filter and update check.
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            state_q <= EAU_ST_IDLE;
            result_q <= EAU_RES_NONE;
            dev_key_q <= 2'h0;
            cbc_q <= 2'h0;
            tamper_q <= 1'b0;
        end else begin
            state_q <= state_d;
            result_q <= result_d;
            if (state_q == EAU_ST_FILTER && state_d == EAU_ST_CHECK) begin
                dev_key_q <= id_idx;
                cbc_q <= rx_cbc;
                tamper_q <= rx_idtype;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register writes; the start bit self-clears and is never stored.
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            ctrl_q <= 32'h0000_0000;
            hdr_q <= 32'h0000_0000;
            id_lo_q <= 32'h0000_0000;
            id_hi_q <= 32'h0000_0000;
            chk_calc_q <= 32'h0000_0000;
            chk_rx_q <= 32'h0000_0000;
            model_lo_q <= 32'h0000_0000;
            model_hi_q <= 32'h0000_0000;
            maker_lo_q <= 32'h0000_0000;
            maker_hi_q <= 32'h0000_0000;
            for (int i = 0; i < `EAU_NUM_PAY; i++) begin
                pay_q[i] <= 32'h0000_0000;
            end
        end else if (wr && !busy) begin
            case (wb_adr_i)
                `EAU_ADR_CTRL: ctrl_q <= merge(ctrl_q, wb_dat_i, wb_sel_i) & 32'h0000_000C;
                `EAU_ADR_HDR: hdr_q <= merge(hdr_q, wb_dat_i, wb_sel_i) & 32'h03FF_FFFF;
                `EAU_ADR_ID_LO: id_lo_q <= merge(id_lo_q, wb_dat_i, wb_sel_i);
                `EAU_ADR_ID_HI: id_hi_q <= merge(id_hi_q, wb_dat_i, wb_sel_i) & 32'h0000_FFFF;
                `EAU_ADR_CHK_CALC: chk_calc_q <= merge(chk_calc_q, wb_dat_i, wb_sel_i);
                `EAU_ADR_CHK_RX: chk_rx_q <= merge(chk_rx_q, wb_dat_i, wb_sel_i);
                `EAU_ADR_MODEL_LO: model_lo_q <= merge(model_lo_q, wb_dat_i, wb_sel_i);
                `EAU_ADR_MODEL_HI: model_hi_q <= merge(model_hi_q, wb_dat_i, wb_sel_i) & 32'h0000_FFFF;
                `EAU_ADR_MAKER_LO: maker_lo_q <= merge(maker_lo_q, wb_dat_i, wb_sel_i);
                `EAU_ADR_MAKER_HI: maker_hi_q <= merge(maker_hi_q, wb_dat_i, wb_sel_i) & 32'h0000_FFFF;
                default: begin
                    for (int i = 0; i < `EAU_NUM_PAY; i++) begin
                        if (wb_adr_i == `EAU_ADR_PAY0 + 8'(4 * i)) begin
                            pay_q[i] <= merge(pay_q[i], wb_dat_i, wb_sel_i);
                        end
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read mux; unmapped addresses read as zero.
    wire [31:0] status = {23'h0, dev_key_q, tamper_q, cbc_q, result_q, busy};
    logic [31:0] rd_d;
    always_comb begin
        rd_d = 32'h0000_0000;
        case (wb_adr_i)
            `EAU_ADR_CTRL: rd_d = ctrl_q;
            `EAU_ADR_HDR: rd_d = hdr_q;
            `EAU_ADR_ID_LO: rd_d = id_lo_q;
            `EAU_ADR_ID_HI: rd_d = id_hi_q;
            `EAU_ADR_CHK_CALC: rd_d = chk_calc_q;
            `EAU_ADR_CHK_RX: rd_d = chk_rx_q;
            `EAU_ADR_STATUS: rd_d = status;
            `EAU_ADR_STORED_UPD: rd_d = {16'h0000, st_upd};
            `EAU_ADR_MODEL_LO: rd_d = model_lo_q;
            `EAU_ADR_MODEL_HI: rd_d = model_hi_q;
            `EAU_ADR_MAKER_LO: rd_d = maker_lo_q;
            `EAU_ADR_MAKER_HI: rd_d = maker_hi_q;
            `EAU_ADR_STORED_DK: rd_d = {gen_maker, gen_model, 16'h0000};
            `EAU_ADR_STORED_DK + 8'h04: rd_d = par_model;
            `EAU_ADR_STORED_DK + 8'h08: rd_d = par_maker;
            default: begin
                for (int i = 0; i < `EAU_NUM_PAY; i++) begin
                    if (wb_adr_i == `EAU_ADR_PAY0 + 8'(4 * i)) begin
                        rd_d = pay_q[i];
                    end
                    if (wb_adr_i == `EAU_ADR_STORED_PAY0 + 8'(4 * i)) begin
                        rd_d = st_wk[i*32 +: 32];
                    end
                end
            end
        endcase
    end

    // Ack one cycle after the request; read data is registered with it.
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            ack_q <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            ack_q <= bus_req;
            if (bus_req) begin
                wb_dat_o <= rd_d;
            end
        end
    end

    assign wb_ack_o = ack_q;
    assign dev_key_sel_o = dev_key_q;
    assign cbc_sel_o = cbc_q;
    assign tamper_key_sel_o = tamper_q;
    assign result_o = result_q;

    ////////////////////////////////////////////////////////////////////////////
    // Checks on the sequencer.
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);

    a_stale_discard: assert property (
        state_q == EAU_ST_FILTER && id_match && rx_upd != `EAU_UPD_NONE && rx_upd <= st_upd
        |=> state_q == EAU_ST_IDLE && result_q == EAU_RES_STALE) else $error("stale message not discarded");
    a_zero_bypass: assert property (
        state_q == EAU_ST_FILTER && id_match && rx_upd == `EAU_UPD_NONE
        |=> state_q == EAU_ST_CHECK) else $error("zero update number was compared");
    a_cbc_pick: assert property (
        state_q == EAU_ST_CHECK |-> cbc_q == $past(rx_cbc)) else $error("wrong CBC selection");
    a_tamper_key: assert property (
        state_q == EAU_ST_CHECK |-> tamper_q == $past(rx_idtype)) else $error("wrong tamper key");
    a_falsified_drop: assert property (
        state_q == EAU_ST_CHECK && !chk_ok |=> result_q == EAU_RES_FALSIFIED ##1 !$past(upd_we))
        else $error("falsified message accepted");
    a_zero_kept: assert property (
        in_store && rx_upd == `EAU_UPD_NONE |=> st_upd == $past(st_upd)) else $error("zero update number stored");
    a_wrap_clear: assert property (
        in_store && rx_upd == `EAU_UPD_WRAP |=> st_upd == `EAU_UPD_NONE) else $error("all-ones not cleared");
    a_id_miss: assert property (
        state_q == EAU_ST_FILTER && !id_match |=> result_q == EAU_RES_ID_MISS ##1 state_q != EAU_ST_STORE)
        else $error("unmatched ID processed");
    a_store_order: assert property (
        in_store |-> $past(state_q) == EAU_ST_CHECK && $past(chk_ok, 1) && $past(state_q, 2) == EAU_ST_FILTER)
        else $error("store out of order");
endmodule : eau_admission

// ===== eau_admission_tb.sv
// Self-checking bench for the message admission and update block.
`include "eau_map.svh"
module eau_admission_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import eau_pkg::*;
    typedef struct packed {
        logic [1:0] stn;
        logic [15:0] upd;
        logic [7:0] pr;
        logic idt;
        logic kd;
        logic [1:0] ids;
        logic ok;
        logic [7:0] gen;
        eau_result_type res;
        logic [15:0] sup;
    } eau_row_type;
    localparam eau_dev_id_type MODEL_ID = 48'h1111_2222_3300;
    localparam eau_dev_id_type MAKER_ID = 48'h4444_5555_6600;
    logic core_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o, q, s_hdr, s_calc, s_rx;
    logic wb_ack_o, tamper_key_sel_o, s_idt, s_kd, s_ok;
    logic [1:0] dev_key_sel_o, cbc_sel_o;
    eau_result_type result_o;
    logic [15:0] s_upd;
    logic [7:0] s_pr, s_gen, s_tag;
    logic [127:0] s_pay;
    int n_mismatch = 0;
    int check_count = 0;
    eau_row_type rows [11];
    logic [127:0] ewk [4];
    logic [7:0] eg [4][2];
    logic [31:0] ep [4][2];
    ////////////////////////////////////////////////////////////
    eau_admission dut (.core_clk_i, .sys_rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
        .wb_dat_i, .wb_dat_o, .wb_ack_o, .dev_key_sel_o, .cbc_sel_o, .tamper_key_sel_o, .result_o);
    eau_emm_src src (.upd_i(s_upd), .proto_i(s_pr), .idt_i(s_idt), .kind_i(s_kd), .chk_ok_i(s_ok),
        .gen_i(s_gen), .tag_i(s_tag), .hdr_o(s_hdr), .calc_o(s_calc), .rx_o(s_rx), .pay_o(s_pay));
    always #4 core_clk_i = ~core_clk_i;
    ////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : tally_and_finish
    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        check_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %0h seen %0h", nm, e, g);
        end
    endtask : chk
    // Holds the request until ack is sampled or 50 cycles pass, then flags a missing ack.
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do begin
            @(posedge core_clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (n >= 50) chk("wb_ack_o", 1, 0);
    endtask : wb
    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(nm, e, q);
    endtask : rdc
    function automatic eau_dev_id_type id_of(input logic [1:0] s);
        case (s)
            2'h0: return MODEL_ID;
            2'h1: return MAKER_ID;
            2'h3: return {MAKER_ID[47:8], 8'h07};
            default: return {MODEL_ID[47:8], 8'h05};
        endcase
    endfunction : id_of
    // Loads one message, starts it, waits for idle and checks what it left behind.
    task automatic run(input eau_row_type r, input logic [7:0] t, input logic poke);
        eau_dev_id_type id;
        int n;
        id = id_of(r.ids);
        s_upd = r.upd;
        s_pr = r.pr;
        s_idt = r.idt;
        s_kd = r.kd;
        s_ok = r.ok;
        s_gen = r.gen;
        s_tag = t;
        #1;
        wb(1'b1, `EAU_ADR_HDR, s_hdr);
        wb(1'b1, `EAU_ADR_ID_LO, id[31:0]);
        wb(1'b1, `EAU_ADR_ID_HI, {16'h0000, id[47:32]});
        wb(1'b1, `EAU_ADR_CHK_CALC, s_calc);
        wb(1'b1, `EAU_ADR_CHK_RX, s_rx);
        for (n = 0; n < 4; n++) wb(1'b1, `EAU_ADR_PAY0 + 8'(4 * n), s_pay[32 * n +: 32]);
        wb(1'b1, `EAU_ADR_CTRL, {28'h0, r.stn, 2'h1});
        // Lands while the run is still busy, so it must be dropped.
        if (poke) wb(1'b1, `EAU_ADR_ID_LO, 32'h0);
        n = 0;
        do begin
            wb(1'b0, `EAU_ADR_STATUS, 32'h0);
            n++;
        end while (q[0] !== 1'b0 && n < 20);
        chk("status result", r.res, q[3:1]);
        chk("result_o", r.res, result_o);
        rdc("stored upd", `EAU_ADR_STORED_UPD, {16'h0000, r.sup});
        if (r.res != EAU_RES_ID_MISS) begin
            chk("dev_key_sel_o", r.ids, dev_key_sel_o);
            chk("cbc_sel_o", r.pr[7:6], cbc_sel_o);
            chk("tamper_key_sel_o", r.idt, tamper_key_sel_o);
        end
        if (r.res == EAU_RES_STORED && r.kd) begin
            eg[r.stn][r.idt] = r.gen;
            ep[r.stn][r.idt] = s_pay[63:32];
        end else if (r.res == EAU_RES_STORED) ewk[r.stn] = s_pay;
        for (n = 0; n < 4; n++) rdc("stored pay", `EAU_ADR_STORED_PAY0 + 8'(4 * n), ewk[r.stn][32 * n +: 32]);
        wb(1'b0, `EAU_ADR_STORED_DK, 32'h0);
        chk("stored gen", {eg[r.stn][1], eg[r.stn][0]}, q[31:16]);
        rdc("maker param", `EAU_ADR_STORED_DK + 8'h08, ep[r.stn][1]);
        rdc("model param", `EAU_ADR_STORED_DK + 8'h04, ep[r.stn][0]);
        // The write that landed while busy must have left the held ID alone.
        if (poke) rdc("held id", `EAU_ADR_ID_LO, id[31:0]);
    endtask : run
    ////////////////////////////////////////////////////////////
    initial begin
        ewk = '{default: '0};
        eg = '{default: '0};
        ep = '{default: '0};
        rows[0] = '{2'h0, 16'h0005, 8'hFF, 1'b0, 1'b0, 2'h0, 1'b1, 8'h00, EAU_RES_STORED, 16'h0005};
        rows[1] = '{2'h0, 16'h0005, 8'hC0, 1'b0, 1'b0, 2'h0, 1'b1, 8'h00, EAU_RES_STALE, 16'h0005};
        rows[2] = '{2'h0, 16'h0003, 8'hC0, 1'b0, 1'b0, 2'h0, 1'b1, 8'h00, EAU_RES_STALE, 16'h0005};
        rows[3] = '{2'h0, 16'h0000, 8'h40, 1'b0, 1'b0, 2'h0, 1'b1, 8'h00, EAU_RES_STORED, 16'h0005};
        rows[4] = '{2'h0, 16'h0006, 8'h80, 1'b0, 1'b0, 2'h0, 1'b0, 8'h00, EAU_RES_FALSIFIED, 16'h0005};
        rows[5] = '{2'h0, 16'hFFFF, 8'h80, 1'b1, 1'b0, 2'h1, 1'b1, 8'h00, EAU_RES_STORED, 16'h0000};
        rows[6] = '{2'h1, 16'h0001, 8'h00, 1'b1, 1'b0, 2'h2, 1'b1, 8'h00, EAU_RES_ID_MISS, 16'h0000};
        rows[7] = '{2'h1, 16'h0001, 8'h3F, 1'b1, 1'b1, 2'h1, 1'b1, 8'h07, EAU_RES_STORED, 16'h0001};
        rows[8] = '{2'h1, 16'h0002, 8'h00, 1'b1, 1'b0, 2'h3, 1'b1, 8'h00, EAU_RES_STORED, 16'h0002};
        rows[9] = '{2'h1, 16'h0003, 8'h00, 1'b0, 1'b1, 2'h0, 1'b1, 8'h05, EAU_RES_STORED, 16'h0003};
        rows[10] = '{2'h1, 16'h0004, 8'h00, 1'b0, 1'b0, 2'h2, 1'b1, 8'h00, EAU_RES_STORED, 16'h0004};
        repeat (16) @(posedge core_clk_i);
        sys_rst_i <= 1'b0;
        wb(1'b1, `EAU_ADR_MODEL_LO, MODEL_ID[31:0]);
        wb(1'b1, `EAU_ADR_MODEL_HI, {16'h0000, MODEL_ID[47:32]});
        wb(1'b1, `EAU_ADR_MAKER_LO, MAKER_ID[31:0]);
        wb(1'b1, `EAU_ADR_MAKER_HI, {16'h0000, MAKER_ID[47:32]});
        for (int i = 0; i < 11; i++) begin
            run(rows[i], 8'(i), 1'b0);
            $display("test %0d done", i);
        end
        // A write while busy must not spoil the ID held for the next message.
        rows[0] = '{2'h2, 16'h0009, 8'h00, 1'b0, 1'b0, 2'h0, 1'b1, 8'h00, EAU_RES_STORED, 16'h0009};
        run(rows[0], 8'h20, 1'b1);
        rows[0].upd = 16'h000A;
        rows[0].sup = 16'h000A;
        run(rows[0], 8'h21, 1'b0);
        rdc("unmapped", 8'hFC, 32'h0);
        $display("test busy and unmapped done");
        // Reset in mid-run clears results and the station memory.
        wb(1'b1, `EAU_ADR_CTRL, 32'h1);
        sys_rst_i <= 1'b1;
        repeat (3) @(posedge core_clk_i);
        chk("result_o", EAU_RES_NONE, result_o);
        chk("wb_ack_o", 1'b0, wb_ack_o);
        sys_rst_i <= 1'b0;
        rdc("stored upd", `EAU_ADR_STORED_UPD, 32'h0);
        $display("test reset done");
        tally_and_finish();
    end
    // Whole run takes about 800 cycles; this cuts a hang short.
    initial begin
        repeat (8000) @(posedge core_clk_i);
        n_mismatch++;
        tally_and_finish();
    end
endmodule : eau_admission_tb

// ===== eau_emm_src.sv
// Broadcast-side source that frames one entitlement message for the bench.
module eau_emm_src (
    // Message fields
    input wire logic [15:0] upd_i,
    input wire logic [7:0] proto_i,
    input wire logic idt_i,
    input wire logic kind_i,
    input wire logic chk_ok_i,
    input wire logic [7:0] gen_i,
    input wire logic [7:0] tag_i,
    // Framed words
    output logic [31:0] hdr_o,
    output logic [31:0] calc_o,
    output logic [31:0] rx_o,
    output logic [127:0] pay_o
);
    timeunit 1ns;
    timeprecision 1ps;
    ////////////////////////////////////////////////////////////
    // Each message travels in a section of its own, so no ID repeats in one.
    // Messages are handed over one block run apart; air time is not modelled.
    assign hdr_o = {6'h00, kind_i, idt_i, proto_i, upd_i};
    assign calc_o = {tag_i, 24'h5EED01};
    // A broken check value goes out only when the bench asks for one.
    assign rx_o = chk_ok_i ? calc_o : ~calc_o;
    // Key updates carry the generation in the low byte and target generation zero IDs.
    assign pay_o = {tag_i, 24'hC0DE03, tag_i, 24'hC0DE02, tag_i, 24'hC0DE01, tag_i, 16'hC0DE, gen_i};
endmodule : eau_emm_src

// ===== eau_id_filter.sv
// Compares the device ID of a message with the two to four IDs the receiver holds.
module eau_id_filter (
    // Received and held identities
    input wire eau_pkg::eau_dev_id_type rx_id_i,
    input wire eau_pkg::eau_dev_id_type model_id_i,
    input wire eau_pkg::eau_dev_id_type maker_id_i,
    input wire logic [7:0] model_gen_i,
    input wire logic [7:0] maker_gen_i,
    // Verdict
    output logic match_o,
    output logic [1:0] match_idx_o
);
    import eau_pkg::*;
    `include "eau_map.svh"

    // A later generation ID is the original with its low byte replaced by the generation number.
    function automatic eau_dev_id_type gen_id(input eau_dev_id_type orig, input logic [7:0] gen);
        gen_id = {orig[47:8], gen};
    endfunction : gen_id

    // Later generation IDs only take part once a generation has been stored.
    wire hit_model = (rx_id_i == model_id_i);
    wire hit_maker = (rx_id_i == maker_id_i);
    wire hit_model_gen = (model_gen_i != `EAU_GEN_ORIG) && (rx_id_i == gen_id(model_id_i, model_gen_i));
    wire hit_maker_gen = (maker_gen_i != `EAU_GEN_ORIG) && (rx_id_i == gen_id(maker_id_i, maker_gen_i));

    // The index names the device key that decrypts the message.
    assign match_o = hit_model | hit_maker | hit_model_gen | hit_maker_gen;
    assign match_idx_o = hit_model ? 2'h0 : hit_maker ? 2'h1 : hit_model_gen ? 2'h2 : 2'h3;
endmodule : eau_id_filter

// ===== eau_map.svh
// Register offsets, field positions and codes of the admission and update block.
`ifndef EAU_MAP_SVH
`define EAU_MAP_SVH
`define EAU_ADR_CTRL 8'h00
`define EAU_ADR_HDR 8'h04
`define EAU_ADR_ID_LO 8'h08
`define EAU_ADR_ID_HI 8'h0C
`define EAU_ADR_CHK_CALC 8'h10
`define EAU_ADR_CHK_RX 8'h14
`define EAU_ADR_PAY0 8'h18
`define EAU_ADR_STATUS 8'h28
`define EAU_ADR_STORED_UPD 8'h2C
`define EAU_ADR_STORED_PAY0 8'h30
`define EAU_ADR_MODEL_LO 8'h40
`define EAU_ADR_MODEL_HI 8'h44
`define EAU_ADR_MAKER_LO 8'h48
`define EAU_ADR_MAKER_HI 8'h4C
`define EAU_ADR_STORED_DK 8'h50
`define EAU_NUM_STATIONS 4
`define EAU_NUM_PAY 4
`define EAU_CTRL_START 0
`define EAU_CTRL_STN_LSB 2
`define EAU_HDR_UPD_MSB 15
`define EAU_HDR_CBC_MSB 23
`define EAU_HDR_CBC_LSB 22
`define EAU_HDR_IDTYPE 24
`define EAU_HDR_KIND 25
`define EAU_UPD_NONE 16'h0000
`define EAU_UPD_WRAP 16'hFFFF
`define EAU_GEN_ORIG 8'h00
`endif

// ===== eau_pkg.sv
// Types shared by the admission and update block.
package eau_pkg;
    typedef enum logic [1:0] {
        EAU_ST_IDLE, EAU_ST_FILTER, EAU_ST_CHECK, EAU_ST_STORE
    } eau_state_type;
    typedef enum logic [2:0] {
        EAU_RES_NONE, EAU_RES_STORED, EAU_RES_ID_MISS, EAU_RES_STALE, EAU_RES_FALSIFIED
    } eau_result_type;
    typedef logic [47:0] eau_dev_id_type;
endpackage : eau_pkg

// ===== eau_station_mem.sv
// Per-station individual data: update number, key-update data and work-key payload.
module eau_station_mem (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    // Station select
    input wire logic [1:0] stn_i,
    // Write strobes and data
    input wire logic upd_we_i,
    input wire logic [15:0] upd_wdata_i,
    input wire logic dk_we_i,
    input wire logic dk_type_i,
    input wire logic [7:0] dk_gen_i,
    input wire logic [31:0] dk_param_i,
    input wire logic wk_we_i,
    input wire logic [127:0] wk_i,
    // Contents of the selected station
    output logic [15:0] upd_o,
    output logic [7:0] gen_model_o,
    output logic [7:0] gen_maker_o,
    output logic [31:0] param_model_o,
    output logic [31:0] param_maker_o,
    output logic [127:0] wk_o
);
    import eau_pkg::*;
    `include "eau_map.svh"

    logic [15:0] upd_q [`EAU_NUM_STATIONS];
    logic [7:0] gen_q [`EAU_NUM_STATIONS][2];
    logic [31:0] param_q [`EAU_NUM_STATIONS][2];
    logic [127:0] wk_q [`EAU_NUM_STATIONS];

    // Storage is cleared at reset so that every station starts at generation zero.
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            for (int s = 0; s < `EAU_NUM_STATIONS; s++) begin
                upd_q[s] <= `EAU_UPD_NONE;
                gen_q[s][0] <= `EAU_GEN_ORIG;
                gen_q[s][1] <= `EAU_GEN_ORIG;
                param_q[s][0] <= 32'h0000_0000;
                param_q[s][1] <= 32'h0000_0000;
                wk_q[s] <= 128'h0;
            end
        end else begin
            if (upd_we_i) begin
                upd_q[stn_i] <= upd_wdata_i;
            end
            if (dk_we_i) begin
                gen_q[stn_i][dk_type_i] <= dk_gen_i;
                param_q[stn_i][dk_type_i] <= dk_param_i;
            end
            if (wk_we_i) begin
                wk_q[stn_i] <= wk_i;
            end
        end
    end

    // Read side for the selected station.
    assign upd_o = upd_q[stn_i];
    assign gen_model_o = gen_q[stn_i][0];
    assign gen_maker_o = gen_q[stn_i][1];
    assign param_model_o = param_q[stn_i][0];
    assign param_maker_o = param_q[stn_i][1];
    assign wk_o = wk_q[stn_i];
endmodule : eau_station_mem
